// ==== src/calendar_pkg.sv ====
/*
  Register map, field layout and timing constants of the BCD clock
  calendar unit. Assumes a 20 MHz system clock and 32-bit Avalon-MM.
*/
package calendar_pkg;
  localparam logic [3:0] OFS_CONTROL    = 4'h0;
  localparam logic [3:0] OFS_TIME       = 4'h4;
  localparam logic [3:0] OFS_DATE       = 4'h8;
  localparam logic [3:0] OFS_ALARM_TIME = 4'hC;
  localparam logic [3:0] OFS_ALARM_DATE = 4'h0;
  localparam int         ALARM_DATE_HI  = 1;
  localparam int BIT_WREN     = 3;
  localparam int BIT_SYNC     = 2;
  localparam int BIT_HALF_SEC = 1;
  // Readable-bit masks per register, then the seconds byte-lane mask for writes
  localparam logic [31:0] MASK_TIME  = 32'h3F7F7F00;
  localparam logic [31:0] MASK_DATE  = 32'hFF1F3F07;
  localparam logic [31:0] MASK_ADATE = 32'h001F3F07;
  localparam logic [31:0] WRITE_SECONDS_BYTE = 32'h0000FF00;
  localparam int CLOCK_HZ   = 20000000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYCLES = CLOCK_HZ / 1000 * HALF_SEC_MS;
  localparam int SYNC_WINDOW_CYCLES = 32;
  localparam logic [3:0] BCD_NINE  = 4'h9;
  localparam logic [3:0] BCD_FIVE  = 4'h5;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [3:0] WDAY_LAST = 4'h6;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  // Saturday 1 Jan 2000
  localparam logic [31:0] DATE_RESET = 32'h00010106;
endpackage : calendar_pkg

// ==== src/clock_calendar_unit.sv ====
/*
  BCD time/date counter with alarm value registers on Avalon-MM.
  Assumes a synchronous master; one clock; no alarm matching here.
*/
// Implementation choices: the placing of the registers and the Avalon-MM register port.
// Contract
// - Hour tens in 31-28 (0-2), units in 27-24 (0-9)
// - Minutes in 23-20 / 19-16; minute tens top bit reads zero
// - Seconds in 15-12 / 11-8; seconds tens top bit reads zero
// - Time low byte reserved; software writes zero, read meaningless
// - Time/date writes ignored unless write enable set
// - Year tens in 31-28, units in 27-24 of date register
// - Month tens 23-20 (upper three bits zero), units 19-16
// - Day tens 15-12 (upper two bits zero), units 11-8
// - Weekday 0-6 in bits 3-0, top bit zero; 7-4 reserved
// - Alarm time register mirrors time layout, low byte reserved
// - Alarm date has month, day, weekday; no year field
// - Hundred-year span with automatic leap year February
// - Range 2000-01-01 00:00:00 to 2099-12-31 23:59:59
// - Time counts whole seconds; half-second status visible
// - Each digit stored as its own 4-bit BCD nibble
// - Write enable set unlocks time and date registers; clear locks them
// - Read-sync high while a rollover ripple may be near
// - Writing seconds clears half-second status
`timescale 1ns/1ps
`default_nettype none
module clock_calendar_unit
  import calendar_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_high,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  logic [31:0] current_time_value;
  logic [31:0] current_date_value;
  logic [31:0] alarm_time_value;
  logic [31:0] alarm_date_value;
  logic        value_write_enable;
  logic        half_second_status;
  logic [23:0] prescale;
  logic        answered;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == BCD_NINE)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Year 00-99: divisible by four means leap, 2000 included
  function automatic logic [7:0] month_last_day(input logic [7:0] month,
                                                input logic [7:0] year);
    logic leap;
    leap = (year[4] == 1'b0) ? (year[1:0] == 2'b00)
                             : (year[1:0] == 2'b10);
    unique case (month)
      8'h02:   month_last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last_day = 8'h30;
      default: month_last_day = 8'h31;
    endcase
  endfunction : month_last_day

  // Address decode; alarm date sits on the high bank
  logic sel_ctrl, sel_time, sel_date, sel_atime, sel_adate;
  logic access;
  assign access    = (avs_read | avs_write) & ~answered;
  assign sel_ctrl  = (avs_address == OFS_CONTROL) & ~avs_high;
  assign sel_time  = (avs_address == OFS_TIME) & ~avs_high;
  assign sel_date  = (avs_address == OFS_DATE) & ~avs_high;
  assign sel_atime = (avs_address == OFS_ALARM_TIME) & ~avs_high;
  assign sel_adate = (avs_address == OFS_ALARM_DATE) & avs_high;

  logic        wr;
  logic [31:0] wmask;
  // Writes commit in the answer cycle, when waitrequest is low
  assign wr    = avs_write & answered;
  assign wmask = lane_mask(avs_byteenable);

  // One wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~answered;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      answered <= 1'b0;
    else
      answered <= access;
  end

  logic tick_half;
  logic tick_second;
  logic sync_near;
  assign tick_half   = (prescale == 24'(HALF_CYCLES - 1));
  assign tick_second = tick_half & half_second_status;
  assign sync_near   = half_second_status &
                       (prescale >= 24'(HALF_CYCLES - SYNC_WINDOW_CYCLES));

  logic time_wr;
  logic sec_wr;
  assign time_wr = wr & sel_time & value_write_enable;
  assign sec_wr  = time_wr & (|(wmask & WRITE_SECONDS_BYTE));

  logic date_wr;
  assign date_wr = wr & sel_date & value_write_enable;

  // Half-second prescaler; restarted by a seconds write
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prescale           <= 24'h000000;
      half_second_status <= 1'b0;
    end else if (sec_wr) begin
      prescale           <= 24'h000000;
      half_second_status <= 1'b0;
    end else if (tick_half) begin
      prescale           <= 24'h000000;
      half_second_status <= ~half_second_status;
    end else begin
      prescale <= prescale + 24'h000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      value_write_enable <= 1'b0;
    else if (wr & sel_ctrl & avs_byteenable[0])
      value_write_enable <= avs_writedata[BIT_WREN];
  end

  // Carry chain; each nibble is one BCD digit
  logic [31:0] next_time, next_date;
  always_comb begin
    logic [7:0] s, m, h, d, mo, y;
    logic [3:0] wd;
    s  = current_time_value[15:8];
    m  = current_time_value[23:16];
    h  = current_time_value[31:24];
    y  = current_date_value[31:24];
    mo = current_date_value[23:16];
    d  = current_date_value[15:8];
    wd = current_date_value[3:0];
    if (s[3:0] == BCD_NINE && s[7:4] == BCD_FIVE) begin
      s = 8'h00;
      if (m[3:0] == BCD_NINE && m[7:4] == BCD_FIVE) begin
        m = 8'h00;
        if (h == HOUR_LAST) begin
          h  = 8'h00;
          wd = (wd == WDAY_LAST) ? 4'h0 : wd + 4'h1;
          if (d == month_last_day(mo, y)) begin
            d = DAY_FIRST;
            if (mo == MONTH_LAST) begin
              mo = DAY_FIRST;
              y  = (y == YEAR_LAST) ? 8'h00 : bcd_inc(y);
            end else begin
              mo = bcd_inc(mo);
            end
          end else begin
            d = bcd_inc(d);
          end
        end else begin
          h = bcd_inc(h);
        end
      end else begin
        m = bcd_inc(m);
      end
    end else begin
      s = bcd_inc(s);
    end
    next_time = {h, m, s, 8'h00};
    next_date = {y, mo, d, 4'h0, wd};
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      current_time_value <= TIME_RESET;
    else if (time_wr)
      current_time_value <= ((current_time_value & ~wmask) |
                             (avs_writedata & wmask)) & MASK_TIME;
    else if (tick_second)
      current_time_value <= next_time;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      current_date_value <= DATE_RESET;
    else if (date_wr)
      current_date_value <= ((current_date_value & ~wmask) |
                             (avs_writedata & wmask)) & MASK_DATE;
    else if (tick_second)
      current_date_value <= next_date;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alarm_time_value <= TIME_RESET;
      alarm_date_value <= 32'h00000000;
    end else begin
      if (wr & sel_atime)
        alarm_time_value <= ((alarm_time_value & ~wmask) |
                             (avs_writedata & wmask)) & MASK_TIME;
      if (wr & sel_adate)
        alarm_date_value <= ((alarm_date_value & ~wmask) |
                             (avs_writedata & wmask)) & MASK_ADATE;
    end
  end

  // Reserved time byte held at zero, so reads give zero there
  always_ff @(posedge mclk) begin
    if (!reset_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read & access) begin
      if (sel_ctrl)
        avs_readdata <= 32'h00000000 |
                        (32'(value_write_enable) << BIT_WREN) |
                        (32'(sync_near) << BIT_SYNC) |
                        (32'(half_second_status) << BIT_HALF_SEC);
      else if (sel_time)
        avs_readdata <= current_time_value;
      else if (sel_date)
        avs_readdata <= current_date_value;
      else if (sel_atime)
        avs_readdata <= alarm_time_value;
      else if (sel_adate)
        avs_readdata <= alarm_date_value;
      else
        avs_readdata <= 32'h00000000;
    end
  end

  property p_locked_time;
    @(posedge mclk) disable iff (!reset_n)
      (wr & sel_time & ~value_write_enable & ~tick_second)
      |=> $stable(current_time_value);
  endproperty
  a_locked_time: assert property (p_locked_time)
    else $error("time changed while locked");

  property p_locked_date;
    @(posedge mclk) disable iff (!reset_n)
      (wr & sel_date & ~value_write_enable & ~tick_second)
      |=> $stable(current_date_value);
  endproperty
  a_locked_date: assert property (p_locked_date)
    else $error("date changed while locked");

  property p_sec_clear;
    @(posedge mclk) disable iff (!reset_n)
      sec_wr |=> !half_second_status;
  endproperty
  a_sec_clear: assert property (p_sec_clear)
    else $error("half-second not cleared by seconds write");

  property p_zero_bits;
    @(posedge mclk) disable iff (!reset_n)
      ((current_time_value & ~MASK_TIME) == 32'h0) &&
      ((current_date_value & ~MASK_DATE) == 32'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("always-zero bit set");

  property p_sec_wrap;
    @(posedge mclk) disable iff (!reset_n)
      (tick_second & ~time_wr && current_time_value[15:8] == 8'h59)
      |=> current_time_value[15:8] == 8'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("seconds did not wrap");

  property p_half_toggle;
    @(posedge mclk) disable iff (!reset_n)
      (tick_half & ~sec_wr) |=> half_second_status != $past(half_second_status);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("half-second did not toggle");

  property p_hour_wrap;
    @(posedge mclk) disable iff (!reset_n)
      (tick_second & ~time_wr && current_time_value[31:8] == 24'h235959)
      |=> current_time_value[31:8] == 24'h000000;
  endproperty
  a_hour_wrap: assert property (p_hour_wrap)
    else $error("day rollover wrong");

  property p_wait_one;
    @(posedge mclk) disable iff (!reset_n)
      (avs_read & ~answered) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer late");

  // Midnight carry into the date, no software write in the way
  logic at_midnight;
  assign at_midnight = tick_second & ~time_wr & ~date_wr &
                       (current_time_value[31:8] == 24'h235959);

  property p_sync_lead;
    @(posedge mclk) disable iff (!reset_n)
      !sync_near |=> (!tick_second) [*8];
  endproperty
  a_sync_lead: assert property (p_sync_lead)
    else $error("second tick without read-sync warning");

  property p_wday_wrap;
    @(posedge mclk) disable iff (!reset_n)
      (at_midnight && current_date_value[3:0] == WDAY_LAST)
      |=> current_date_value[3:0] == 4'h0;
  endproperty
  a_wday_wrap: assert property (p_wday_wrap)
    else $error("weekday did not wrap");

  property p_year_wrap;
    @(posedge mclk) disable iff (!reset_n)
      (at_midnight && current_date_value[31:8] == 24'h991231)
      |=> current_date_value[31:8] == 24'h000101;
  endproperty
  a_year_wrap: assert property (p_year_wrap)
    else $error("century end did not wrap");

  property p_leap_feb;
    @(posedge mclk) disable iff (!reset_n)
      (at_midnight && current_date_value[23:8] == 16'h0228 &&
       current_date_value[31:24] inside {8'h00, 8'h24})
      |=> current_date_value[23:8] == 16'h0229;
  endproperty
  a_leap_feb: assert property (p_leap_feb)
    else $error("leap February lost its last day");

  property p_common_feb;
    @(posedge mclk) disable iff (!reset_n)
      (at_midnight && current_date_value[31:8] == 24'h230228)
      |=> current_date_value[23:8] == 16'h0301;
  endproperty
  a_common_feb: assert property (p_common_feb)
    else $error("common February ran past its end");

endmodule : clock_calendar_unit
`default_nettype wire

// ==== sim/sw_master.sv ====
/*
  Software-side bus master model for the clock calendar unit.
  Assumes one clock and an Avalon-MM slave with waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module sw_master
  import calendar_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        waitreq,
  input  wire logic [31:0] rdata,
  output logic             hi,
  output logic [3:0]       addr,
  output logic             rd,
  output logic             wr,
  output logic [31:0]      wdata,
  output logic [3:0]       be
);
  initial begin
    {hi, addr, rd, wr, wdata, be} = '0;
  end
  // Request held until waitrequest seen low at a rising edge
  task automatic xfer(input logic w, input logic h, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    @(posedge mclk);
    {hi, addr, rd, wr, wdata, be} <= {h, a, !w, w, d, b};
    // No cycle count assumed; the bench watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (waitreq !== 1'b0);
    q = rdata;
    {rd, wr} <= 2'b00;
  endtask : xfer
  // Access the value registers only outside the ripple window
  task automatic wait_sync_clear();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 64 && c[BIT_SYNC] !== 1'b0; i++)
      xfer(1'b0, 1'b0, OFS_CONTROL, 32'h0, 4'hF, c);
  endtask : wait_sync_clear
endmodule : sw_master
`default_nettype wire

// ==== sim/clock_calendar_unit_tb.sv ====
/*
  Self-checking bench for the clock calendar unit.
  Assumes the software master model and a shortened half-second.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_calendar_unit_tb;
  import calendar_pkg::*;
  localparam int HC = 40;
  localparam int CY[5] = '{24, 0, 23, 99, 98};
  localparam int CM[5] = '{2, 2, 2, 12, 4};
  localparam int CD[5] = '{28, 28, 28, 31, 30};
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hi, rd, wr, waitreq;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, q;
  int          err_total = 0;
  int          num_checks = 0;
  int          seed = 32'h6D0B;
  int          y, mo, d, wd, h, mi, s;
  always #25 mclk = ~mclk;
  clock_calendar_unit #(.HALF_CYCLES(HC)) dut (.mclk(mclk),
    .reset_n(reset_n), .avs_address(addr), .avs_high(hi), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq));
  sw_master u_sw (.mclk(mclk), .waitreq(waitreq), .rdata(rdata), .hi(hi),
    .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .be(be));
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction : bcd
  function automatic int mdays(input int yy, input int mm);
    if (mm == 2) return (yy % 4 == 0) ? 29 : 28;
    return (mm == 4 || mm == 6 || mm == 9 || mm == 11) ? 30 : 31;
  endfunction : mdays
  function automatic void step();
    s = (s + 1) % 60;
    if (s == 0) mi = (mi + 1) % 60;
    if (s == 0 && mi == 0) h = (h + 1) % 24;
    if (s == 0 && mi == 0 && h == 0) begin
      wd = (wd + 1) % 7;
      d = d % mdays(y, mo) + 1;
      if (d == 1) mo = mo % 12 + 1;
      if (d == 1 && mo == 1) y = (y + 1) % 100;
    end
  endfunction : step
  function automatic logic [31:0] tval();
    return {bcd(h), bcd(mi), bcd(s), 8'h00};
  endfunction : tval
  function automatic logic [31:0] dval();
    return {bcd(y), bcd(mo), bcd(d), 4'h0, 4'(wd)};
  endfunction : dval
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic hb, input logic [3:0] a,
                      input logic [31:0] v, input logic [3:0] b);
    u_sw.xfer(1'b1, hb, a, v, b, q);
  endtask : wreg
  task automatic rreg(input logic hb, input logic [3:0] a);
    u_sw.xfer(1'b0, hb, a, 32'h0, 4'hF, q);
  endtask : rreg
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rreg(1'b0, OFS_TIME);
    chk(q & 32'hFFFFFF00, 32'h0);
    rreg(1'b0, OFS_DATE);
    chk(q & 32'hFFFFFF00, 32'h00010100);
    rreg(1'b0, OFS_CONTROL);
    chk(q & 32'h8, 32'h0);
    wreg(1'b0, OFS_TIME, 32'h12345600, 4'hF);
    rreg(1'b0, OFS_TIME);
    chk(q & 32'hFFFF0000, 32'h0);
    wreg(1'b0, OFS_DATE, 32'h24022803, 4'hF);
    rreg(1'b0, OFS_DATE);
    chk(q & 32'hFFFFFF00, 32'h00010100);
    rreg(1'b1, 4'h4);
    chk(q, 32'h0);
    wreg(1'b0, OFS_CONTROL, 32'h8, 4'hF);
    rreg(1'b0, OFS_CONTROL);
    chk(q & 32'h8, 32'h8);
    wreg(1'b0, OFS_ALARM_TIME, 32'hFFFFFFFF, 4'hF);
    rreg(1'b0, OFS_ALARM_TIME);
    chk(q & 32'hFFFFFF00, MASK_TIME);
    wreg(1'b0, OFS_ALARM_TIME, 32'h00001200, 4'h2);
    rreg(1'b0, OFS_ALARM_TIME);
    chk(q & 32'hFFFFFF00, 32'h3F7F1200);
    wreg(1'b1, OFS_ALARM_DATE, 32'hFFFFFFFF, 4'hF);
    rreg(1'b1, OFS_ALARM_DATE);
    chk(q & 32'h00FFFF0F, MASK_ADATE);
    for (int i = 0; i < 12; i++) begin
      y = $unsigned($random(seed)) % 100;
      mo = $unsigned($random(seed)) % 12 + 1;
      d = $unsigned($random(seed)) % mdays(y, mo) + 1;
      wd = $unsigned($random(seed)) % 7;
      h = $unsigned($random(seed)) % 24;
      mi = $unsigned($random(seed)) % 60;
      s = (i % 2 == 1) ? 59 : $unsigned($random(seed)) % 60;
      // Month, year and leap-day boundaries at midnight
      if (i < 5) begin
        y = CY[i];
        mo = CM[i];
        d = CD[i];
        wd = 6 - i;
        h = 23;
        mi = 59;
        s = 59;
      end
      u_sw.wait_sync_clear();
      wreg(1'b0, OFS_DATE, dval(), 4'hF);
      wreg(1'b0, OFS_TIME, tval(), 4'hF);
      repeat (10) @(posedge mclk);
      rreg(1'b0, OFS_CONTROL);
      chk(q & 32'h6, 32'h0);
      repeat (40) @(posedge mclk);
      rreg(1'b0, OFS_CONTROL);
      chk(q & 32'h6, 32'h6);
      repeat (40) @(posedge mclk);
      step();
      rreg(1'b0, OFS_TIME);
      chk(q & 32'hFFFFFF00, tval());
      rreg(1'b0, OFS_DATE);
      chk(q & 32'hFFFFFF0F, dval());
    end
    wreg(1'b0, OFS_CONTROL, 32'h0, 4'hF);
    wreg(1'b0, OFS_TIME, 32'h11223300, 4'hF);
    wreg(1'b0, OFS_DATE, 32'h11021103, 4'hF);
    rreg(1'b0, OFS_TIME);
    chk(q & 32'hFFFFFF00, tval());
    rreg(1'b0, OFS_DATE);
    chk(q & 32'hFFFFFF0F, dval());
    wreg(1'b0, OFS_ALARM_TIME, 32'h12345600, 4'hF);
    rreg(1'b0, OFS_ALARM_TIME);
    chk(q & 32'hFFFFFF00, 32'h12345600);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
endmodule : clock_calendar_unit_tb
`default_nettype wire
